/* wit_map.svh */
`ifndef WIT_MAP_SVH
`define WIT_MAP_SVH
// register addresses
`define WIT_ADDR_CTL 16'hffa8
`define WIT_ADDR_CNT 16'hffa9
// write passwords in the upper byte
`define WIT_PWD_CNT 8'h5a
`define WIT_PWD_CTL 8'ha5
// control/status field positions
`define WIT_BIT_OVF 7
`define WIT_BIT_MODE 6
`define WIT_BIT_EN 5
`define WIT_BIT_ONE 4
`define WIT_BIT_RSEL 3
`define WIT_CKS_HI 2
`define WIT_CKS_LO 0
// reset values and counter maximum
`define WIT_CTL_RESET 8'h10
`define WIT_CNT_RESET 8'h00
`define WIT_CNT_MAX 8'hff
`define WIT_OVF_RESET 1'b0
// internal reset length in system clocks
`define WIT_RST_CLOCKS 518
`define WIT_RST_CYCLES (`WIT_RST_CLOCKS)
`define WIT_RST_CW 10
// prescaler tap bit for each clock select code
`define WIT_TAPS '{11, 10, 8, 7, 6, 5, 4, 0}
`endif

/* wit_pkg.sv */
package wit_pkg;
  // internal reset sequencer
  typedef enum logic {WIT_IDLE, WIT_HOLD} wit_rst_state_type;
  typedef logic [2:0] wit_cks_type;
endpackage

/* wit_pre_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface wit_pre_if;
  import wit_pkg::*;
  logic run;
  wit_cks_type cks;
  logic tick;
  modport ctl (output run, output cks, input tick);
  modport pre (input run, input cks, output tick);
endinterface
`default_nettype wire

/* wit_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wit_map.svh"
module wit_prescaler
  import wit_pkg::*;
#(
  parameter int PRE_W = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  wit_pre_if.pre pre
);
  localparam int TAP [8] = `WIT_TAPS;
  logic [PRE_W-1:0] div_ff;
  logic [PRE_W-1:0] nxt_div;
  logic tick_ff;
  logic nxt_tick;
  logic [7:0] hit;

  // width check at elaboration
  if (PRE_W < 12) begin : g_pre_w
    $error("prescaler too narrow for the divide-by-4096 tap");
  end

  // one divide tap per clock select code
  for (genvar g = 0; g < 8; g++) begin : g_tap
    assign hit[g] = &div_ff[TAP[7-g]:0];
  end

  // divider restarts while counting is stopped
  always_comb begin
    nxt_div = pre.run ? div_ff + 1'b1 : '0;
    nxt_tick = pre.run & hit[pre.cks];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign pre.tick = tick_ff;
endmodule
`default_nettype wire

/* wit_watchdog.sv */
// What this block does
// - flag set by external, cleared by watchdog reset
// - only word writes reach counter or control
// - upper byte password selects counter or control
// - byte reads at two addresses, no password
// - mode and enable set start the watchdog
// - overflow: 518-clock reset or nmi request
// - requests share external reset and nmi vectors
// - interval mode requests on every overflow
// - overflow flag set with the request
// - reset-out pin low with internal reset
// - counter write beats a coincident increment
// - standby clears counter and all control but clock select
// - 8-bit counter on one of eight divides
// - disabled counter held at zero
// - flag clears by zero write after read
// - control layout: mode, enable, one, reset select
`timescale 1ns/100ps
`default_nettype none
`include "wit_map.svh"
module wit_watchdog
  import wit_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_word,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic chip_reset_b,
  output logic reset_out_pin_b,
  output logic nmi_req,
  output logic interval_overflow_request,
  output logic reset_source_flag
);
  wit_pre_if pre_if ();
  wit_rst_state_type state_ff, nxt_state;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic ovf_ff, nxt_ovf, ovf_seen_ff, nxt_ovf_seen;
  logic mode_ff, nxt_mode, en_ff, nxt_en, rsel_ff, nxt_rsel;
  wit_cks_type cks_ff, nxt_cks;
  logic [`WIT_RST_CW-1:0] hold_ff, nxt_hold;
  logic [7:0] rdata_ff, nxt_rdata;
  logic chip_rst_b_ff, nxt_chip_rst_b, reset_out_pin_b_ff, nxt_reset_out_pin_b;
  logic nmi_ff, nxt_nmi, irq_ff, nxt_irq, flag_ff, nxt_flag;
  logic wr_hit, wr_cnt, wr_ctl, ovf_evt, wdt_rst_evt;
  logic [7:0] ctl_view;

  // width check at elaboration
  if (CNT_W != 8) begin : g_cnt_w
    $error("counter width must be 8");
  end

  wit_prescaler #(.PRE_W(12)) u_pre (
    .clk(clk),
    .rst_b(rst_b),
    .pre(pre_if.pre)
  );
  assign pre_if.run = en_ff;
  assign pre_if.cks = cks_ff;

  // write decode: word write, shared address, password byte
  assign wr_hit = bus_wr & bus_word & (bus_addr == `WIT_ADDR_CTL);
  assign wr_cnt = wr_hit & (bus_wdata[15:8] == `WIT_PWD_CNT);
  assign wr_ctl = wr_hit & (bus_wdata[15:8] == `WIT_PWD_CTL);
  // overflow on wrap, lost if a counter write lands in the same cycle
  assign ovf_evt = en_ff & pre_if.tick & (count_ff == `WIT_CNT_MAX) & ~wr_cnt;
  assign wdt_rst_evt = ovf_evt & mode_ff & rsel_ff;
  assign ctl_view = {ovf_ff, mode_ff, en_ff, 1'b1, rsel_ff, cks_ff};

  // counter and control/status next values
  always_comb begin
    nxt_count = count_ff;
    nxt_mode = mode_ff;
    nxt_en = en_ff;
    nxt_rsel = rsel_ff;
    nxt_cks = cks_ff;
    nxt_ovf = ovf_ff;
    nxt_ovf_seen = ovf_seen_ff;
    if (wr_cnt) begin
      nxt_count = bus_wdata[7:0];
    end else if (en_ff && pre_if.tick) begin
      nxt_count = count_ff + 1'b1;
    end
    if (wr_ctl) begin
      nxt_mode = bus_wdata[`WIT_BIT_MODE];
      nxt_en = bus_wdata[`WIT_BIT_EN];
      nxt_rsel = bus_wdata[`WIT_BIT_RSEL];
      nxt_cks = bus_wdata[`WIT_CKS_HI:`WIT_CKS_LO];
      if (!bus_wdata[`WIT_BIT_OVF] && ovf_seen_ff) begin
        nxt_ovf = 1'b0;
        nxt_ovf_seen = 1'b0;
      end
    end
    if (bus_rd && bus_addr == `WIT_ADDR_CTL && ovf_ff) begin
      nxt_ovf_seen = 1'b1;
    end
    if (ovf_evt) begin
      nxt_ovf = 1'b1;
    end
    if (!en_ff) begin
      nxt_count = `WIT_CNT_RESET;
    end
    if (standby || state_ff == WIT_HOLD) begin
      nxt_count = `WIT_CNT_RESET;
      nxt_mode = 1'b0;
      nxt_en = 1'b0;
      nxt_rsel = 1'b0;
      if (standby) begin
        nxt_ovf = 1'b0;
        nxt_ovf_seen = 1'b0;
      end
    end
  end

  // internal reset sequencer, outside the reset it makes
  always_comb begin
    nxt_state = state_ff;
    nxt_hold = hold_ff;
    nxt_flag = flag_ff;
    unique case (state_ff)
      WIT_IDLE: begin
        if (wdt_rst_evt) begin
          nxt_state = WIT_HOLD;
          nxt_hold = `WIT_RST_CW'(`WIT_RST_CYCLES - 1);
          nxt_flag = 1'b0;
        end
      end
      WIT_HOLD: begin
        if (hold_ff == '0) begin
          nxt_state = WIT_IDLE;
        end else begin
          nxt_hold = hold_ff - 1'b1;
        end
      end
    endcase
    nxt_chip_rst_b = ~(nxt_state == WIT_HOLD);
    nxt_reset_out_pin_b = ~(nxt_state == WIT_HOLD);
    nxt_nmi = ovf_evt & mode_ff & ~rsel_ff;
    nxt_irq = ovf_evt & ~mode_ff;
  end

  // byte read port, no password
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus_rd && bus_addr == `WIT_ADDR_CTL) begin
      nxt_rdata = ctl_view;
    end else if (bus_rd && bus_addr == `WIT_ADDR_CNT) begin
      nxt_rdata = count_ff;
    end
  end

  // the flag only sees the external reset as a set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= WIT_IDLE;
      hold_ff <= '0;
      flag_ff <= 1'b1;
      count_ff <= `WIT_CNT_RESET;
      ovf_ff <= `WIT_OVF_RESET;
      ovf_seen_ff <= 1'b0;
      mode_ff <= 1'b0;
      en_ff <= 1'b0;
      rsel_ff <= 1'b0;
      cks_ff <= '0;
      rdata_ff <= 8'h00;
      chip_rst_b_ff <= 1'b1;
      reset_out_pin_b_ff <= 1'b1;
      nmi_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hold_ff <= nxt_hold;
      flag_ff <= nxt_flag;
      count_ff <= nxt_count;
      ovf_ff <= nxt_ovf;
      ovf_seen_ff <= nxt_ovf_seen;
      mode_ff <= nxt_mode;
      en_ff <= nxt_en;
      rsel_ff <= nxt_rsel;
      cks_ff <= nxt_cks;
      rdata_ff <= nxt_rdata;
      chip_rst_b_ff <= nxt_chip_rst_b;
      reset_out_pin_b_ff <= nxt_reset_out_pin_b;
      nmi_ff <= nxt_nmi;
      irq_ff <= nxt_irq;
    end
  end

  assign bus_rdata = rdata_ff;
  assign chip_reset_b = chip_rst_b_ff;
  assign reset_out_pin_b = reset_out_pin_b_ff;
  assign nmi_req = nmi_ff;
  assign interval_overflow_request = irq_ff;
  assign reset_source_flag = flag_ff;

  // helper: length of the internal reset pulse
  logic [`WIT_RST_CW:0] low_len;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_len <= '0;
    end else begin
      low_len <= chip_rst_b_ff ? '0 : low_len + 1'b1;
    end
  end

  a_rst_length: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(chip_rst_b_ff) |-> $past(low_len) == `WIT_RST_CYCLES - 1)
    else $error("internal reset length wrong");
  a_reset_out_pin_follows: assert property (@(posedge clk) disable iff (!rst_b)
    reset_out_pin_b_ff == chip_rst_b_ff)
    else $error("reset-out differs from internal reset");
  a_reset_out_pin_low: assert property (@(posedge clk) disable iff (!rst_b)
    wdt_rst_evt |=> !reset_out_pin_b_ff && !chip_rst_b_ff)
    else $error("reset-out not low after watchdog overflow");
  a_flag_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(chip_rst_b_ff) |-> !flag_ff)
    else $error("reset source flag not cleared");
  a_ovf_with_req: assert property (@(posedge clk) disable iff (!rst_b)
    ovf_evt |=> ovf_ff && (nmi_ff || irq_ff || !chip_rst_b_ff))
    else $error("overflow flag and request not together");
  a_nmi_mode: assert property (@(posedge clk) disable iff (!rst_b)
    nmi_ff |-> $past(mode_ff) && !$past(rsel_ff) && $past(count_ff) == 8'hff)
    else $error("nmi outside watchdog nmi mode");
  a_interval_req: assert property (@(posedge clk) disable iff (!rst_b)
    irq_ff |-> !$past(mode_ff) && $past(en_ff))
    else $error("interval request outside interval mode");
  a_hold_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !en_ff |=> count_ff == 8'h00)
    else $error("disabled counter not zero");
  a_byte_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_wr && !bus_word && !standby && state_ff == WIT_IDLE) |=> $stable(cks_ff) && $stable(mode_ff))
    else $error("byte write changed control");
  a_cnt_load: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_cnt && en_ff && !standby && state_ff == WIT_IDLE) |=> count_ff == $past(bus_wdata[7:0]))
    else $error("counter write not loaded");
  a_ctl_read: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_rd && bus_addr == `WIT_ADDR_CTL) |=> bus_rdata[`WIT_BIT_ONE] && bus_rdata[2:0] == $past(cks_ff))
    else $error("control read wrong");
endmodule
`default_nettype wire

/* wit_dummy_end.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* wit_watchdog_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module wit_watchdog_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic standby = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_word = 1'b0;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic chip_reset_b;
  logic reset_out_pin_b;
  logic nmi_req;
  logic interval_overflow_request;
  logic reset_source_flag;
  int err_total = 0;
  int tests_run = 0;
  int n;
  int t1;
  int dv[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
  // 40 mhz system clock
  always #12.5 clk = ~clk;
  wit_watchdog dut (
    .clk(clk),
    .rst_b(rst_b),
    .standby(standby),
    .bus_addr(bus_addr),
    .bus_wr(bus_wr),
    .bus_word(bus_word),
    .bus_wdata(bus_wdata),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .chip_reset_b(chip_reset_b),
    .reset_out_pin_b(reset_out_pin_b),
    .nmi_req(nmi_req),
    .interval_overflow_request(interval_overflow_request),
    .reset_source_flag(reset_source_flag)
  );
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // closing report
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one write strobe, password in the upper byte
  task automatic wr(input logic [7:0] pw, input logic [7:0] d, input logic w = 1'b1);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_word <= w;
    bus_addr <= 16'hffa8;
    bus_wdata <= {pw, d};
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // one read strobe, data taken the cycle after
  task automatic rc(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, bus_rdata});
  endtask
  function automatic logic ev(input int k);
    case (k)
      0: return interval_overflow_request === 1'b1;
      1: return nmi_req === 1'b1;
      default: return chip_reset_b === 1'b0;
    endcase
  endfunction
  // bounded wait for a request
  task automatic wt(input int k);
    for (n = 0; n < 200 && !ev(k); n++) begin
      @(posedge clk);
      #1;
    end
    if (!ev(k)) begin
      err_total++;
      $display("BAD wait %0d expected event seen none", k);
      print_verdict();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // reset state and read map
    rc("ctl", 16'hffa8, 8'h10);
    rc("cnt", 16'hffa9, 8'h00);
    rc("unmapped", 16'hffaa, 8'h00);
    chk("flag", 16'h1, {15'h0, reset_source_flag});
    // refused writes
    wr(8'ha5, 8'h60, 1'b0);
    rc("ctl", 16'hffa8, 8'h10);
    wr(8'h33, 8'h60);
    rc("ctl", 16'hffa8, 8'h10);
    // count write and read back on slowest clock
    wr(8'ha5, 8'h27);
    wr(8'h5a, 8'hfe);
    rc("cnt", 16'hffa9, 8'hfe);
    wr(8'ha5, 8'h07);
    // interval overflow; count write lands on a tick
    wr(8'ha5, 8'h20);
    @(posedge clk);
    wr(8'h5a, 8'hfe);
    rc("cnt", 16'hffa9, 8'hfe);
    wt(0);
    rc("ctl", 16'hffa8, 8'hb0);
    wr(8'ha5, 8'h80);
    rc("ctl", 16'hffa8, 8'h90);
    rc("cnt", 16'hffa9, 8'h00);
    wr(8'ha5, 8'h00);
    rc("ctl", 16'hffa8, 8'h10);
    // watchdog nmi
    wr(8'ha5, 8'h60);
    wr(8'h5a, 8'hfe);
    wt(1);
    chk("crst", 16'h1, {15'h0, chip_reset_b});
    rc("ctl", 16'hffa8, 8'hf0);
    wr(8'ha5, 8'h60);
    // regular rewrites keep the count from wrapping
    repeat (300) wr(8'h5a, 8'h00);
    rc("ctl", 16'hffa8, 8'h70);
    wr(8'ha5, 8'h00);
    // watchdog reset
    wr(8'ha5, 8'h68);
    wr(8'h5a, 8'hfe);
    wt(2);
    chk("rout", 16'h0, {15'h0, reset_out_pin_b});
    chk("flag", 16'h0, {15'h0, reset_source_flag});
    for (n = 0; n < 600 && chip_reset_b === 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 600) begin
      err_total++;
      $display("BAD rlen expected release seen none");
      print_verdict();
    end
    chk("rlen", 16'd518, 16'(n));
    rc("ctl", 16'hffa8, 8'h90);
    // standby keeps only clock select
    wr(8'ha5, 8'ha7);
    wr(8'h5a, 8'h40);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rc("ctl", 16'hffa8, 8'h17);
    rc("cnt", 16'hffa9, 8'h00);
    // tick spacing for each clock select code
    for (int c = 0; c < 8; c++) begin
      wr(8'ha5, 8'h00);
      wr(8'ha5, 8'h20 | 8'(c));
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= 16'hffa9;
      t1 = -1;
      for (n = 0; n < 13000; n++) begin
        @(posedge clk);
        #1;
        if (bus_rdata === 8'h02 && t1 < 0) t1 = n;
        if (bus_rdata === 8'h03) break;
      end
      if (n == 13000) begin
        err_total++;
        $display("BAD div %0d expected count 3 seen none", c);
        print_verdict();
      end
      @(posedge clk);
      bus_rd <= 1'b0;
      chk("div", 16'(dv[c]), 16'(n - t1));
    end
    // second external reset sets the flag again
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rc("ctl", 16'hffa8, 8'h10);
    chk("flag", 16'h1, {15'h0, reset_source_flag});
    print_verdict();
  end
endmodule
`default_nettype wire
